// ---- tbdl_top.sv ----
/*
  Button decision logic for a four-channel inductive touch converter:
  thresholds, baseline tracking, group rejection, output and interrupt pins,
  and the Wishbone register file.
  Assumes the converter delivers one raw count per channel at the end of each
  sampling window on SAMPLE_VALID, in the REF_CLK domain.
*/
// Contract
// - Press declared when button signal reaches 128 plus hysteresis.
// - Pressed button released when signal falls to 128 minus hysteresis.
// - Hysteresis resets to 32, giving thresholds 160 and 96.
// - Normal mode baseline step is two to the index over 72.
// - Low mode baseline step is two to the index over 9.
// - Tracking-hold bit stops tracking while that channel's output is asserted.
// - Negative button signal multiplies baseline step by fast tracking factor.
// - Fast tracking field codes 0,1,2,3 give factors 1,4,8,16.
// - Shared-press group suppresses common-mode detections between buttons.
// - Strongest-press group reports only the button with largest signal.
// - Case-torsion rejection suppresses presses while a signal is too negative.
// - Deformation group filters changes caused by nearby metal deformation.
// - Interrupt pin asserted while a press or error is present.
// - Interrupt pin active low after reset; polarity setting can invert.
// - Output and interrupt assert at end of window after press.
// - Output stays asserted until end of window after release.
// - Output-change flag set on first assertion, cleared by status read.
// - Interrupt stays asserted while at least one button is pressed.
// - Errors assert the interrupt and are recorded in status register.
`timescale 1ns/1ps
`default_nettype none

module tbdl_top (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  // Converter samples
  input  wire logic        SAMPLE_VALID,
  input  wire logic [1:0]  SAMPLE_CH,
  input  wire logic [15:0] SAMPLE_RAW,
  input  wire logic        ERROR_EVENT,
  // Pins
  input  wire logic        POWER_MODE_PIN,
  output var  logic [3:0]  BUTTON_OUT_PIN,
  output var  logic        IRQ_PIN,
  output var  logic [7:0]  COUNTER_SCALE_SHIFT
);

  // Fast tracking code to shift amount.
  function automatic logic [3:0] ft_shift(input logic [1:0] sel);
    logic [3:0] s;
    s = 4'h0;
    case (sel)
      2'b00: s = 4'h0;
      2'b01: s = 4'h2;
      2'b10: s = 4'h3;
      default: s = 4'h4;
    endcase
    return s;
  endfunction : ft_shift

  logic        pm_s1_q, pm_s2_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [7:0]  pol_q, lp_q, np_q, hold_max_q, hysteresis_setting_q, twist_q, groups_q, cnt_q;
  logic [7:0]  ft0_q, ft12_q, ft3_q;
  logic [3:0]  pressed_q, seen_q;
  logic        out_st_q, err_q, irq_q;
  logic [15:0] base_q [tbdl_pkg::NCH];
  logic [6:0]  frac_q [tbdl_pkg::NCH];
  logic signed [16:0] data_q [tbdl_pkg::NCH];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pm_s1_q <= 1'b0;
      pm_s2_q <= 1'b0;
    end else begin
      pm_s1_q <= POWER_MODE_PIN;
      pm_s2_q <= pm_s1_q;
    end
  end

  // Bus decode.
  wire       req      = WB_CYC_I & WB_STB_I & ~ack_q;
  wire [5:0] idx      = WB_ADR_I[7:2];
  wire       wr       = req & WB_WE_I & WB_SEL_I[0];
  wire       rd_stat  = req & ~WB_WE_I & (idx == tbdl_pkg::IDX_STATUS);
  wire [7:0] wd       = WB_DAT_I[7:0];
  logic [7:0] rmux;

  always_comb begin
    if (idx == tbdl_pkg::IDX_STATUS)
      rmux = {pressed_q, 2'b00, err_q, out_st_q};
    else if (idx == tbdl_pkg::IDX_IRQ_POL)   rmux = pol_q;
    else if (idx == tbdl_pkg::IDX_LP_STEP)   rmux = lp_q;
    else if (idx == tbdl_pkg::IDX_NP_STEP)   rmux = np_q;
    else if (idx == tbdl_pkg::IDX_HOLD_MAX)  rmux = hold_max_q;
    else if (idx == tbdl_pkg::IDX_HYSTERESIS_SETTING)      rmux = hysteresis_setting_q;
    else if (idx == tbdl_pkg::IDX_TWIST)     rmux = twist_q;
    else if (idx == tbdl_pkg::IDX_GROUPS)    rmux = groups_q;
    else if (idx == tbdl_pkg::IDX_CNT_SCALE) rmux = cnt_q;
    else if (idx == tbdl_pkg::IDX_FT0)       rmux = ft0_q;
    else if (idx == tbdl_pkg::IDX_FT12)      rmux = ft12_q;
    else if (idx == tbdl_pkg::IDX_FT3)       rmux = ft3_q;
    else                                     rmux = 8'h00;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? {24'h00_0000, rmux} : 32'h0000_0000;
    end
  end

  // hysteresis reset value, polarity reset active low
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pol_q      <= tbdl_pkg::REG_RST;
      lp_q       <= tbdl_pkg::REG_RST;
      np_q       <= tbdl_pkg::REG_RST;
      hold_max_q <= tbdl_pkg::REG_RST;
      hysteresis_setting_q     <= tbdl_pkg::HYSTERESIS_SETTING_RST;
      twist_q    <= tbdl_pkg::REG_RST;
      groups_q   <= tbdl_pkg::REG_RST;
      cnt_q      <= tbdl_pkg::REG_RST;
      ft0_q      <= tbdl_pkg::REG_RST;
      ft12_q     <= tbdl_pkg::REG_RST;
      ft3_q      <= tbdl_pkg::REG_RST;
    end else if (wr) begin
      if (idx == tbdl_pkg::IDX_IRQ_POL)        pol_q      <= wd;
      else if (idx == tbdl_pkg::IDX_LP_STEP)   lp_q       <= wd;
      else if (idx == tbdl_pkg::IDX_NP_STEP)   np_q       <= wd;
      else if (idx == tbdl_pkg::IDX_HOLD_MAX)  hold_max_q <= wd;
      else if (idx == tbdl_pkg::IDX_HYSTERESIS_SETTING)      hysteresis_setting_q     <= wd;
      else if (idx == tbdl_pkg::IDX_TWIST)     twist_q    <= wd;
      else if (idx == tbdl_pkg::IDX_GROUPS)    groups_q   <= wd;
      else if (idx == tbdl_pkg::IDX_CNT_SCALE) cnt_q      <= wd;
      else if (idx == tbdl_pkg::IDX_FT0)       ft0_q      <= wd;
      else if (idx == tbdl_pkg::IDX_FT12)      ft12_q     <= wd;
      else if (idx == tbdl_pkg::IDX_FT3)       ft3_q      <= wd;
    end
  end

  // Group masks and per-channel fast tracking codes.
  wire [3:0] hold_en   = hold_max_q[tbdl_pkg::HOLD_LSB +: 4];
  wire [3:0] maxwin_en = hold_max_q[tbdl_pkg::MAXWIN_LSB +: 4];
  wire [3:0] common_en = groups_q[tbdl_pkg::COMMON_LSB +: 4];
  wire [3:0] deform_en = groups_q[tbdl_pkg::DEFORM_LSB +: 4];
  wire [1:0] ft_sel [tbdl_pkg::NCH];
  assign ft_sel[0] = ft0_q[tbdl_pkg::FT_LO_LSB +: 2];
  assign ft_sel[1] = ft12_q[tbdl_pkg::FT_LO_LSB +: 2];
  assign ft_sel[2] = ft12_q[tbdl_pkg::FT_HI_LSB +: 2];
  assign ft_sel[3] = ft3_q[tbdl_pkg::FT_LO_LSB +: 2];

  wire signed [16:0] on_thr  = tbdl_pkg::NOM_THR + $signed({9'h000, hysteresis_setting_q});
  wire signed [16:0] off_thr = tbdl_pkg::NOM_THR - $signed({9'h000, hysteresis_setting_q});
  wire signed [16:0] neg_hys = -$signed({9'h000, hysteresis_setting_q});
  wire signed [16:0] twist_thr = -$signed({10'h000, twist_q[6:0]});

  // The first window of a channel only captures its baseline.
  wire [1:0]  c       = SAMPLE_CH;
  wire        first   = ~seen_q[c];
  wire signed [16:0] d_new = first ? 17'h00000 :
                             $signed({1'b0, SAMPLE_RAW}) - $signed({1'b0, base_q[c]});

  logic signed [16:0] dv [tbdl_pkg::NCH];
  logic [3:0] hit;
  logic       twist_blk, sup_common, sup_max, sup_deform;

  always_comb begin
    twist_blk  = 1'b0;
    sup_common = 1'b0;
    sup_max    = 1'b0;
    sup_deform = 1'b0;
    for (int i = 0; i < tbdl_pkg::NCH; i++) begin
      dv[i]  = (i == int'(c)) ? d_new : data_q[i];
      hit[i] = pressed_q[i] ? (dv[i] > off_thr) : (dv[i] >= on_thr);
      if (twist_q[tbdl_pkg::TWIST_EN_BIT] && (dv[i] < twist_thr))
        twist_blk = 1'b1;
    end
    for (int j = 0; j < tbdl_pkg::NCH; j++) begin
      if (j != int'(c)) begin
        // comparable response on another member
        // Doubling in 18 bits keeps a large neighbour from wrapping negative.
        if (common_en[c] && common_en[j] && hit[j] &&
            ($signed({dv[j], 1'b0}) >= dv[c]))
          sup_common = 1'b1;
        if (maxwin_en[c] && maxwin_en[j] && hit[j] && (dv[j] > dv[c]))
          sup_max = 1'b1;
        if (deform_en[c] && deform_en[j] && (dv[j] < neg_hys))
          sup_deform = 1'b1;
      end
    end
  end

  // decision for the channel at its window end
  wire press_new = hit[c] & ~sup_common & ~sup_max & ~sup_deform & ~twist_blk & ~first;
  wire rise      = SAMPLE_VALID & press_new & ~pressed_q[c];
  wire [3:0] pressed_d = SAMPLE_VALID ? ((pressed_q & ~(4'h1 << c)) |
                                         ({3'h0, press_new} << c)) : pressed_q;

  // normal-mode step, low-mode step (72/9 = 8 units), fast factor
  wire        neg     = d_new[16];
  wire [3:0]  sh_mode = pm_s2_q ? 4'h0 : tbdl_pkg::LP_STEP_SHIFT;
  wire [3:0]  sh_ft   = neg ? ft_shift(ft_sel[c]) : 4'h0;
  wire [2:0]  s_idx   = pm_s2_q ? np_q[2:0] : lp_q[2:0];
  wire [15:0] step    = 16'h0001 << ({1'b0, s_idx} + sh_mode + sh_ft);
  wire [15:0] total   = {9'h000, frac_q[c]} + step;
  wire [15:0] inc     = total / tbdl_pkg::STEP_DIV;
  wire [6:0]  rem     = 7'(total % tbdl_pkg::STEP_DIV);
  wire [16:0] mag     = neg ? 17'(-d_new) : 17'(d_new);
  wire        hold    = hold_en[c] & pressed_q[c];
  // Clamping at the raw count keeps the baseline from overshooting the input.
  wire [15:0] base_d  = first ? SAMPLE_RAW :
                        ({1'b0, inc} >= mag) ? SAMPLE_RAW :
                        neg ? 16'(base_q[c] - inc) : 16'(base_q[c] + inc);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seen_q <= 4'h0;
      for (int i = 0; i < tbdl_pkg::NCH; i++) begin
        base_q[i] <= 16'h0000;
        frac_q[i] <= 7'h00;
        data_q[i] <= 17'h00000;
      end
    end else if (SAMPLE_VALID) begin
      seen_q[c] <= 1'b1;
      data_q[c] <= d_new;
      if (!hold && (d_new != 17'h00000 || first)) begin
        base_q[c] <= base_d;
        frac_q[c] <= first ? 7'h00 : rem;
      end
    end
  end

  // set wins over read clear, error recorded
  wire out_st_d = rise | (out_st_q & ~rd_stat);
  wire err_d    = ERROR_EVENT | (err_q & ~rd_stat);
  // press or error, level while any pressed, polarity
  wire irq_d    = ((|pressed_d) | err_d) ? pol_q[0] : ~pol_q[0];

  // assert at window end, hold until window after release
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pressed_q <= 4'h0;
      out_st_q  <= 1'b0;
      err_q     <= 1'b0;
      irq_q     <= 1'b1;
    end else begin
      pressed_q <= pressed_d;
      out_st_q  <= out_st_d;
      err_q     <= err_d;
      irq_q     <= irq_d;
    end
  end

  assign WB_ACK_O            = ack_q;
  assign WB_DAT_O            = rdat_q;
  assign BUTTON_OUT_PIN      = pressed_q;
  assign IRQ_PIN             = irq_q;
  // scaler handed to the frequency counter
  assign COUNTER_SCALE_SHIFT = cnt_q;

  // Helper state for the checks below.
  logic [1:0] ch_q;
  logic       rise_q, off_q, hold_q, twist_q1;
  logic [15:0] base_was_q;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ch_q       <= 2'h0;
      rise_q     <= 1'b0;
      off_q      <= 1'b0;
      hold_q     <= 1'b0;
      twist_q1   <= 1'b0;
      base_was_q <= 16'h0000;
    end else begin
      ch_q       <= c;
      rise_q     <= rise;
      off_q      <= SAMPLE_VALID & pressed_q[c] & (d_new <= off_thr);
      hold_q     <= SAMPLE_VALID & hold;
      twist_q1   <= SAMPLE_VALID & twist_blk;
      base_was_q <= base_q[c];
    end
  end

  a_press_sets_pin: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_VALID && !pressed_q[c] && !first && d_new >= on_thr && !sup_common && !sup_max
    && !sup_deform && !twist_blk |=> BUTTON_OUT_PIN[ch_q] && IRQ_PIN == $past(pol_q[0]))
    else $error("press over on-level did not assert pin and irq");
  a_release_clears_pin: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    off_q |-> !BUTTON_OUT_PIN[ch_q])
    else $error("release at off-level kept the pin asserted");
  a_below_on_no_press: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_VALID && !pressed_q[c] && d_new < on_thr |=> !BUTTON_OUT_PIN[ch_q])
    else $error("pin asserted below on-level");
  a_hysteresis_setting_after_reset: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !$past(RST_N) |-> hysteresis_setting_q == tbdl_pkg::HYSTERESIS_SETTING_RST && IRQ_PIN)
    else $error("hysteresis or irq level wrong after reset");
  a_irq_while_pressed: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (|BUTTON_OUT_PIN) && $stable(pol_q) |-> IRQ_PIN == pol_q[0])
    else $error("irq not asserted while a button is pressed");
  a_status_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    rise_q |-> out_st_q ##1 (out_st_q || $past(rd_stat)))
    else $error("output-change flag not set on assertion");
  a_status_read_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    rd_stat && !rise |=> !out_st_q)
    else $error("status read did not clear output-change flag");
  a_hold_freezes: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    hold_q |-> base_q[ch_q] == base_was_q)
    else $error("baseline moved while tracking was held");
  a_twist_blocks: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    twist_q1 |-> !BUTTON_OUT_PIN[ch_q])
    else $error("press reported during case torsion");
  a_error_irq: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ERROR_EVENT && $stable(pol_q) |=> err_q && IRQ_PIN == $past(pol_q[0]))
    else $error("error did not raise irq and status");
  a_ack_single: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");
  a_ack_follows_req: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request was not answered in the next cycle");
  a_err_read_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    rd_stat && !ERROR_EVENT |=> !err_q)
    else $error("status read did not clear the error flag");
  a_irq_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !(|BUTTON_OUT_PIN) && !err_q && $stable(pol_q) |-> IRQ_PIN == !pol_q[0])
    else $error("irq asserted with no press and no error");

  // Group suppressions are checked one cycle on, on the channel just evaluated.
  // A suppressed or first sample must never leave its pin asserted.
  a_shared_suppress: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_VALID && sup_common |=> !BUTTON_OUT_PIN[ch_q])
    else $error("shared-press suppression left the pin asserted");
  a_strongest_only: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_VALID && sup_max |=> !BUTTON_OUT_PIN[ch_q])
    else $error("weaker strongest-group member reported");
  a_deform_suppress: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_VALID && sup_deform |=> !BUTTON_OUT_PIN[ch_q])
    else $error("deformation suppression left the pin asserted");
  a_first_no_press: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_VALID && first |=> !BUTTON_OUT_PIN[ch_q])
    else $error("first sample of a channel reported a press");

  c_press: cover property (@(posedge REF_CLK) disable iff (!RST_N) rise);
  c_release: cover property (@(posedge REF_CLK) disable iff (!RST_N) off_q);
  c_twist: cover property (@(posedge REF_CLK) disable iff (!RST_N) twist_q1);
  c_stat_read: cover property (@(posedge REF_CLK) disable iff (!RST_N) rd_stat && out_st_q);
  c_shared: cover property (@(posedge REF_CLK) disable iff (!RST_N) SAMPLE_VALID && sup_common);

endmodule : tbdl_top

`default_nettype wire

// ---- tbdl_pkg.sv ----
/*
  Constants for the touch button detect logic: register indices, field
  positions, reset values and tracking constants.
  Assumes a 32-bit classic Wishbone bus where register index i sits at byte 4*i.
*/
`default_nettype none

package tbdl_pkg;
  localparam int          NCH            = 4;
  // Register indices; byte address is four times the index.
  localparam logic [5:0]  IDX_STATUS     = 6'h00;
  localparam logic [5:0]  IDX_IRQ_POL    = 6'h11;
  localparam logic [5:0]  IDX_LP_STEP    = 6'h13;
  localparam logic [5:0]  IDX_NP_STEP    = 6'h15;
  localparam logic [5:0]  IDX_HOLD_MAX   = 6'h16;
  localparam logic [5:0]  IDX_HYSTERESIS_SETTING       = 6'h18;
  localparam logic [5:0]  IDX_TWIST      = 6'h19;
  localparam logic [5:0]  IDX_GROUPS     = 6'h1a;
  localparam logic [5:0]  IDX_CNT_SCALE  = 6'h1e;
  localparam logic [5:0]  IDX_FT0        = 6'h25;
  localparam logic [5:0]  IDX_FT12       = 6'h28;
  localparam logic [5:0]  IDX_FT3        = 6'h2b;
  // Reset values.
  localparam logic [7:0]  HYSTERESIS_SETTING_RST       = 8'h20;
  localparam logic [7:0]  REG_RST        = 8'h00;
  // Status fields.
  localparam int          ST_OUT_BIT     = 0;
  localparam int          ST_ERR_BIT     = 1;
  localparam int          ST_PRESS_LSB   = 4;
  // Group fields.
  localparam int          HOLD_LSB       = 0;
  localparam int          MAXWIN_LSB     = 4;
  localparam int          COMMON_LSB     = 0;
  localparam int          DEFORM_LSB     = 4;
  localparam int          TWIST_EN_BIT   = 7;
  localparam int          FT_LO_LSB      = 0;
  localparam int          FT_HI_LSB      = 4;
  // Threshold and tracking.
  localparam logic signed [16:0] NOM_THR = 17'h00080;
  localparam logic [15:0] STEP_DIV       = 16'h0048;
  localparam logic [3:0]  LP_STEP_SHIFT  = 4'h3;
endpackage : tbdl_pkg

`default_nettype wire

// ---- tbdl_conv_model.sv ----
/*
  Converter-side model: one raw count per sampling window, and error pulses.
  Assumes the bench calls its tasks from one process, timed by REF_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module tbdl_conv_model (
  // Clock
  input  wire logic        clk,
  // Sample stream
  output var  logic        valid,
  output var  logic [1:0]  ch,
  output var  logic [15:0] raw,
  output var  logic        err
);
  initial begin
    valid = 1'b0;
    ch    = 2'h0;
    raw   = 16'h5a5a;
    err   = 1'b0;
  end

  // one count per window
  // Between windows the stream shows the inverse count, so a held value is never trusted.
  task automatic send(input logic [1:0] c, input logic [15:0] r, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    valid <= 1'b1;
    ch    <= c;
    raw   <= r;
    @(posedge clk);
    valid <= 1'b0;
    ch    <= ~c;
    raw   <= ~r;
  endtask : send

  task automatic fault();
    @(posedge clk);
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
  endtask : fault
endmodule : tbdl_conv_model

`default_nettype wire

// ---- testbench.sv ----
/*
  Self-checking bench for the touch button detect logic.
  Assumes tbdl_pkg, tbdl_top and the converter model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk, rst_n, cyc, stb, we, sv, err_ev, pm, irq, ack;
  logic [7:0]  adr, css, q, d;
  logic [3:0]  sel, bout;
  logic [31:0] wdat, rdat;
  logic [1:0]  sch;
  logic [15:0] sraw;
  logic [15:0] b [4];
  logic        pol;
  int          n_errors, cmp_count, cyc_cnt, seed;

  tbdl_top tbdl_top_inst (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SAMPLE_VALID(sv), .SAMPLE_CH(sch), .SAMPLE_RAW(sraw),
    .ERROR_EVENT(err_ev), .POWER_MODE_PIN(pm), .BUTTON_OUT_PIN(bout), .IRQ_PIN(irq),
    .COUNTER_SCALE_SHIFT(css));
  tbdl_conv_model tbdl_conv_model_inst (.clk(clk), .valid(sv), .ch(sch), .raw(sraw),
    .err(err_ev));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [4:0] pex(input logic [3:0] o, input logic e);
    return {((|o) | e) ? pol : ~pol, o};
  endfunction : pex

  function automatic logic [15:0] ft_mul(input int code);
    case (code)
      0: return 16'h0001;
      1: return 16'h0004;
      2: return 16'h0008;
      default: return 16'h0010;
    endcase
  endfunction : ft_mul

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [4:0] e);
    cmp_count++;
    if ({irq, bout} !== e) begin
      n_errors++;
      $display("unexpected pins expected %h seen %h", e, {irq, bout});
    end
  endtask : chk_pin

  // The request stays put until ack is sampled high at a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dd);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, dd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    // The slave registers its answer, so ack is seen at the second edge after launch.
    chk_reg("bus ack latency", 8'h02, 8'(n));
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk_reg($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic smp(input logic [1:0] c, input logic [15:0] r);
    tbdl_conv_model_inst.send(c, r, int'($urandom % 3));
    @(negedge clk);
  endtask : smp

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  initial begin
    {cyc, stb, we, adr, wdat} = '0;
    sel   = 4'hf;
    pol   = 1'b0;
    rst_n = 1'b0;
    pm    = 1'b1;
    seed  = $urandom(70);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_pin(pex(4'h0, 1'b0));
    rd(8'h60, tbdl_pkg::HYSTERESIS_SETTING_RST);
    rd(8'h00, 8'h00);
    rd(8'h44, 8'h00);
    wb(1'b1, 8'hfc, 8'hff);
    rd(8'hfc, 8'h00);
    for (int i = 0; i < 4; i++) begin
      logic [7:0] a;
      a = (i == 0) ? 8'h60 : (i == 1) ? 8'h68 : (i == 2) ? 8'h64 : 8'h78;
      d = 8'($urandom);
      wb(1'b1, a, d);
      rd(a, d);
      if (a == 8'h78) chk_reg("scale pin", d, css);
      wb(1'b1, a, (a == 8'h60) ? tbdl_pkg::HYSTERESIS_SETTING_RST : 8'h00);
    end
    done("registers");
    wb(1'b1, 8'h58, 8'h01);
    b[0] = 16'd1000 + 16'($urandom % 30000);
    smp(2'd0, b[0]);
    smp(2'd0, b[0] + 16'd159);
    chk_pin(pex(4'h0, 1'b0));
    smp(2'd0, b[0] + 16'd161);
    chk_pin(pex(4'h1, 1'b0));
    rd(8'h00, 8'h11);
    rd(8'h00, 8'h10);
    smp(2'd0, b[0] + 16'd98);
    chk_pin(pex(4'h1, 1'b0));
    smp(2'd0, b[0] + 16'd96);
    chk_pin(pex(4'h0, 1'b0));
    done("threshold");
    b[1] = 16'd1000 + 16'($urandom % 30000);
    smp(2'd0, b[0] + 16'd200);
    smp(2'd1, b[1]);
    smp(2'd1, b[1] + 16'd200);
    chk_pin(pex(4'h3, 1'b0));
    smp(2'd0, b[0] - 16'd50);
    chk_pin(pex(4'h2, 1'b0));
    smp(2'd1, b[1] - 16'd50);
    chk_pin(pex(4'h0, 1'b0));
    rd(8'h00, 8'h01);
    done("two buttons");
    wb(1'b1, 8'h44, 8'h01);
    pol = 1'b1;
    repeat (2) @(negedge clk);
    chk_pin(pex(4'h0, 1'b0));
    tbdl_conv_model_inst.fault();
    repeat (2) @(negedge clk);
    chk_pin(pex(4'h0, 1'b1));
    rd(8'h00, 8'h02);
    repeat (2) @(negedge clk);
    chk_pin(pex(4'h0, 1'b0));
    done("error");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    pol = 1'b0;
    @(negedge clk);
    chk_pin(pex(4'h0, 1'b0));
    wb(1'b1, 8'ha0, 8'h21);
    wb(1'b1, 8'hac, 8'h03);
    for (int c = 0; c < 4; c++) begin
      b[c] = 16'd1000 + 16'($urandom % 30000);
      smp(2'(c), b[c]);
      repeat (72) smp(2'(c), b[c] - 16'd100);
      b[c] = b[c] - ft_mul(c);
      smp(2'(c), b[c] + 16'd158);
      chk_pin(pex(4'h0, 1'b0));
      smp(2'(c), b[c] + 16'd161);
      chk_pin(pex(4'h1 << c, 1'b0));
      smp(2'(c), b[c] - 16'd500);
    end
    done("fast tracking");
    wb(1'b1, 8'h58, 8'hc0);
    smp(2'd2, b[2] + 16'd200);
    smp(2'd3, b[3] + 16'd300);
    smp(2'd2, b[2] + 16'd200);
    chk_pin(pex(4'h8, 1'b0));
    smp(2'd2, b[2] - 16'd50);
    smp(2'd3, b[3] - 16'd50);
    done("strongest");
    wb(1'b1, 8'h64, 8'hb2);
    smp(2'd1, b[1] - 16'd80);
    smp(2'd0, b[0] + 16'd200);
    chk_pin(pex(4'h0, 1'b0));
    smp(2'd1, b[1]);
    smp(2'd0, b[0] + 16'd200);
    chk_pin(pex(4'h1, 1'b0));
    rd(8'h00, 8'h11);
    done("torsion");
    wb(1'b1, 8'h64, 8'h00);
    wb(1'b1, 8'h68, 8'h03);
    smp(2'd1, b[1] + 16'd180);
    chk_pin(pex(4'h1, 1'b0));
    smp(2'd0, b[0] + 16'd200);
    chk_pin(pex(4'h0, 1'b0));
    smp(2'd1, b[1]);
    smp(2'd0, b[0] + 16'd200);
    chk_pin(pex(4'h1, 1'b0));
    done("shared press");
    wb(1'b1, 8'h68, 8'h30);
    smp(2'd1, b[1] - 16'd40);
    smp(2'd0, b[0] + 16'd200);
    chk_pin(pex(4'h0, 1'b0));
    smp(2'd1, b[1]);
    smp(2'd0, b[0] + 16'd200);
    chk_pin(pex(4'h1, 1'b0));
    done("deformation");
    wb(1'b1, 8'h68, 8'h00);
    wb(1'b1, 8'h60, 8'h10);
    smp(2'd0, b[0]);
    smp(2'd2, b[2] + 16'd143);
    chk_pin(pex(4'h0, 1'b0));
    smp(2'd2, b[2] + 16'd144);
    chk_pin(pex(4'h4, 1'b0));
    smp(2'd2, b[2] + 16'd113);
    chk_pin(pex(4'h4, 1'b0));
    smp(2'd2, b[2] + 16'd112);
    chk_pin(pex(4'h0, 1'b0));
    done("programmed hysteresis");
    @(posedge clk);
    pm <= 1'b0;
    repeat (3) @(posedge clk);
    // Nine low-mode steps add 72 units, one whole count whatever fraction was left.
    repeat (9) smp(2'd3, b[3] + 16'd100);
    b[3] = b[3] + 16'd1;
    smp(2'd3, b[3] + 16'd143);
    chk_pin(pex(4'h0, 1'b0));
    smp(2'd3, b[3] + 16'd144);
    chk_pin(pex(4'h8, 1'b0));
    wb(1'b1, 8'h58, 8'hc8);
    repeat (9) smp(2'd3, b[3] + 16'd200);
    smp(2'd3, b[3] + 16'd113);
    chk_pin(pex(4'h8, 1'b0));
    smp(2'd3, b[3]);
    chk_pin(pex(4'h0, 1'b0));
    done("low power");
    close_out();
  end
endmodule : testbench

`default_nettype wire
